// ===== src/lts_sequencer.v
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "lts_consts.vh"
module lts_sequencer #(
   parameter ENHANCED = 1,
   parameter TICK_CYC = `LTS_CLK_HZ / 1000 * `LTS_DWELL_UNIT_MS
) (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // external trigger
   input  wire        trig_in,
   // output stage
   output reg  [15:0] level_out,
   output reg  [31:0] slew_out,
   output reg  [1:0]  mode_out,
   output reg  [10:0] phase_a_out,
   output reg  [10:0] phase_b_out,
   output reg  [10:0] phase_c_out,
   output reg         marker_out,
   output reg         busy_out
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_DWELL = 2'h1;
   localparam ST_WAIT  = 2'h2;

   reg        wr_q;
   reg [7:0]  wa_q;
   reg        once_q;
   reg        three_q;
   reg [27:0] count_q;
   reg [9:0]  pha_q;
   reg [9:0]  phb_q;
   reg [9:0]  phc_q;
   reg [1:0]  mode_nx_q;
   reg        pend_q;
   reg [1:0]  st_q;
   reg [4:0]  cur_q;
   reg [4:0]  nxt_q;
   reg [27:0] pass_q;
   reg [6:0]  rep_q;
   reg [26:0] dcnt_q;
   reg [26:0] dcur_q;
   reg [14:0] div_q;
   reg [31:0] rd_d;

   wire        we = wr_q;
   wire [31:0] wd = hwdata;
   wire        take = hsel && hready && htrans[1];
   wire        cmd_we = we && wa_q == `LTS_A_CMD;
   wire        trig = trig_in || (cmd_we && wd[`LTS_CMD_TRIG]);
   wire        clr = cmd_we && wd[`LTS_CMD_CLEAR];

   // list pushes; slew, dwell and repeat pushes are range checked
   wire        slew_ok = (wd == `LTS_SLEW_MAX) ||
                         (!wd[31] && wd[30:0] >= `LTS_SLEW_DMIN) ||
                         (wd[31] && wd[30:0] != 31'h0 &&
                          wd[30:0] <= `LTS_SLEW_UMAX);
   wire        p_volt = we && wa_q == `LTS_A_VOLT;
   wire        p_slew = we && wa_q == `LTS_A_SLEW && slew_ok;
   wire        p_dwel = we && wa_q == `LTS_A_DWELL &&
                        wd[26:0] != 27'h0 && wd[31:27] == 5'h00 &&
                        wd[26:0] <= `LTS_DWELL_MAX;
   wire        p_rep  = we && wa_q == `LTS_A_REP &&
                        wd[31:7] == 25'h0 &&
                        wd[6:0] <= `LTS_REP_MAX;
   wire        p_mark = we && wa_q == `LTS_A_MARK;
   wire        list_wr = clr || p_volt || p_slew || p_dwel ||
                         p_rep || p_mark;

   wire        mode_ok = wd[1:0] == `LTS_MODE_AC ||
                         wd[1:0] == `LTS_MODE_DC ||
                         (ENHANCED != 0 &&
                          wd[1:0] == `LTS_MODE_COMB);
   wire        mode_chg = we && wa_q == `LTS_A_MODE && mode_ok &&
                          wd[31:2] == 30'h0 && wd[1:0] != mode_out;
   wire        abort = (cmd_we && wd[`LTS_CMD_ABORT]) ||
                       (list_wr && st_q != ST_IDLE) || mode_chg;

   wire [5:0]  vcnt;
   wire [5:0]  scnt;
   wire [5:0]  dwcnt;
   wire [5:0]  rcnt;
   wire [5:0]  mcnt;
   wire [15:0] v_val;
   wire [31:0] s_val;
   wire [26:0] d_val;
   wire [6:0]  r_val;
   wire [0:0]  m_val;
   // a single dwell entry serves every point
   wire [4:0]  d_addr = (dwcnt == 6'h01) ? 5'h00 : nxt_q;

   lts_list #(.W(16)) u_volt (.hclk(hclk), .hresetn(hresetn),
      .clr(clr), .push(p_volt), .din(wd[15:0]), .addr(nxt_q),
      .dout(v_val), .count(vcnt));
   lts_list #(.W(32)) u_slew (.hclk(hclk), .hresetn(hresetn),
      .clr(clr), .push(p_slew), .din(wd), .addr(nxt_q),
      .dout(s_val), .count(scnt));
   lts_list #(.W(27)) u_dwel (.hclk(hclk), .hresetn(hresetn),
      .clr(clr), .push(p_dwel), .din(wd[26:0]), .addr(d_addr),
      .dout(d_val), .count(dwcnt));
   lts_list #(.W(7)) u_rep (.hclk(hclk), .hresetn(hresetn),
      .clr(clr), .push(p_rep), .din(wd[6:0]), .addr(nxt_q),
      .dout(r_val), .count(rcnt));
   lts_list #(.W(1)) u_mark (.hclk(hclk), .hresetn(hresetn),
      .clr(clr), .push(p_mark), .din(wd[0]), .addr(nxt_q),
      .dout(m_val), .count(mcnt));

   // sequencing events
   wire tick = div_q == TICK_CYC[14:0] - 15'h0001;
   wire last_pt = {1'b0, cur_q} == vcnt - 6'h01;
   wire expire = st_q == ST_DWELL && tick && dcnt_q <= 27'h1;
   wire rep_more = expire && rep_q != 7'h00;
   wire fin = expire && !rep_more && last_pt &&
              pass_q == count_q;
   wire start = st_q == ST_IDLE && trig && vcnt != 6'h00 && !abort && !pend_q;
   wire adv_auto = expire && !rep_more && !fin && !once_q;
   wire to_wait = expire && !rep_more && !fin && once_q;
   wire step = st_q == ST_WAIT && trig && !abort;
   wire load = (start || adv_auto || step) && !abort;

   // ahb-lite address phase capture, zero wait states
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q      <= 1'b0;
         wa_q      <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_q <= take && hwrite;
         if (take) begin
            wa_q <= haddr[7:0];
         end
         if (take && !hwrite) begin
            hrdata <= rd_d;
         end
      end
   end

   // read decode; list offsets return their lengths
   always @* begin
      if (haddr[31:8] != 24'h0 || haddr[1:0] != 2'h0) begin
         rd_d = 32'h00000000;
      end else if (haddr[7:0] == `LTS_A_CTRL) begin
         rd_d = {30'h0, three_q, once_q};
      end else if (haddr[7:0] == `LTS_A_MODE) begin
         rd_d = {30'h0, mode_out};
      end else if (haddr[7:0] == `LTS_A_COUNT) begin
         rd_d = {4'h0, count_q};
      end else if (haddr[7:0] == `LTS_A_PHA) begin
         rd_d = {{22{pha_q[9]}}, pha_q};
      end else if (haddr[7:0] == `LTS_A_PHB) begin
         rd_d = {{22{phb_q[9]}}, phb_q};
      end else if (haddr[7:0] == `LTS_A_PHC) begin
         rd_d = {{22{phc_q[9]}}, phc_q};
      end else if (haddr[7:0] == `LTS_A_LEVEL) begin
         rd_d = {16'h0, level_out};
      end else if (haddr[7:0] == `LTS_A_STATUS) begin
         rd_d = {pass_q, 2'h0, st_q} | {19'h0, cur_q, 8'h0};
      end else if (haddr[7:0] == `LTS_A_VOLT) begin
         rd_d = {26'h0, vcnt};
      end else if (haddr[7:0] == `LTS_A_SLEW) begin
         rd_d = {26'h0, scnt};
      end else if (haddr[7:0] == `LTS_A_DWELL) begin
         rd_d = {26'h0, dwcnt};
      end else if (haddr[7:0] == `LTS_A_REP) begin
         rd_d = {26'h0, rcnt};
      end else if (haddr[7:0] == `LTS_A_MARK) begin
         rd_d = {26'h0, mcnt};
      end else begin
         rd_d = 32'h00000000;
      end
   end

   // configuration registers
   wire ph_ok = !wd[9] ? wd[9:0] <= `LTS_PH_MAX :
                (-wd[9:0]) <= `LTS_PH_MAX;
   wire ph_we = we && ph_ok && wd[31:10] == {22{wd[9]}};
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         once_q  <= 1'b0;
         three_q <= 1'b0;
         count_q <= `LTS_RST_COUNT;
         pha_q   <= 10'h000;
         phb_q   <= 10'h000;
         phc_q   <= 10'h000;
      end else begin
         if (we && wa_q == `LTS_A_CTRL) begin
            once_q  <= wd[`LTS_CTRL_ONCE];
            three_q <= wd[`LTS_CTRL_3PH];
         end
         if (we && wa_q == `LTS_A_COUNT && wd[31:28] == 4'h0 &&
             wd[27:0] != 28'h0 && wd[27:0] <= `LTS_COUNT_MAX) begin
            count_q <= wd[27:0];
         end
         if (ph_we && wa_q == `LTS_A_PHA) begin
            pha_q <= wd[9:0];
         end
         if (ph_we && wa_q == `LTS_A_PHB) begin
            phb_q <= wd[9:0];
         end
         if (ph_we && wa_q == `LTS_A_PHC) begin
            phc_q <= wd[9:0];
         end
      end
   end

   // phase outputs: a against reference, b and c against a
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_a_out <= 11'h000;
         phase_b_out <= 11'h000;
         phase_c_out <= 11'h000;
      end else begin
         phase_a_out <= {pha_q[9], pha_q};
         if (three_q) begin
            phase_b_out <= {pha_q[9], pha_q} + {phb_q[9], phb_q};
            phase_c_out <= {pha_q[9], pha_q} + {phc_q[9], phc_q};
         end else begin
            phase_b_out <= 11'h000;
            phase_c_out <= 11'h000;
         end
      end
   end

   // mode switch: level goes to zero one cycle before the mode moves
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_out <= `LTS_RST_MODE;
         mode_nx_q <= `LTS_RST_MODE;
         pend_q   <= 1'b0;
      end else begin
         pend_q <= mode_chg;
         if (mode_chg) begin
            mode_nx_q <= wd[1:0];
         end
         if (pend_q) begin
            mode_out <= mode_nx_q;
         end
      end
   end

   // list sequencer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q       <= ST_IDLE;
         cur_q      <= 5'h00;
         nxt_q      <= 5'h00;
         pass_q     <= 28'h0;
         rep_q      <= 7'h00;
         dcnt_q     <= 27'h0;
         dcur_q     <= 27'h0;
         div_q      <= 15'h0000;
         level_out  <= 16'h0000;
         slew_out   <= `LTS_SLEW_MAX;
         marker_out <= 1'b0;
         busy_out   <= 1'b0;
      end else begin
         marker_out <= load && m_val[0];
         busy_out   <= load || (st_q != ST_IDLE && !abort && !fin);
         div_q <= (load || tick) ? 15'h0000 : div_q + 15'h0001;
         if (mode_chg || pend_q) begin
            level_out <= 16'h0000;
         end else if (load) begin
            level_out <= v_val;
         end else if (we && wa_q == `LTS_A_LEVEL) begin
            level_out <= wd[15:0];
         end
         if (abort) begin
            st_q  <= ST_IDLE;
            nxt_q <= 5'h00;
         end else if (load) begin
            st_q   <= ST_DWELL;
            slew_out <= ({1'b0, nxt_q} >= scnt) ? `LTS_SLEW_MAX : s_val;
            dcnt_q <= d_val;
            dcur_q <= d_val;
            rep_q  <= r_val;
            cur_q  <= nxt_q;
            nxt_q  <= ({1'b0, nxt_q} == vcnt - 6'h01) ? 5'h00 :
                      nxt_q + 5'h01;
            if (start) begin
               pass_q <= 28'h1;
            end else if (nxt_q == 5'h00) begin
               pass_q <= pass_q + 28'h1;
            end
         end else if (rep_more) begin
            rep_q  <= rep_q - 7'h01;
            dcnt_q <= dcur_q;
         end else if (fin) begin
            st_q  <= ST_IDLE;
            nxt_q <= 5'h00;
         end else if (to_wait) begin
            st_q <= ST_WAIT;
         end else if (st_q == ST_DWELL && tick && dcnt_q > 27'h1) begin
            dcnt_q <= dcnt_q - 27'h1;
         end
      end
   end
endmodule // lts_sequencer

// ===== src/lts_consts.vh
`ifndef LTS_CONSTS_VH
`define LTS_CONSTS_VH
// register byte offsets
`define LTS_A_CTRL      8'h00
`define LTS_A_MODE      8'h04
`define LTS_A_COUNT     8'h08
`define LTS_A_PHA       8'h0C
`define LTS_A_PHB       8'h10
`define LTS_A_PHC       8'h14
`define LTS_A_LEVEL     8'h18
`define LTS_A_CMD       8'h1C
`define LTS_A_STATUS    8'h20
`define LTS_A_VOLT      8'h40
`define LTS_A_SLEW      8'h44
`define LTS_A_DWELL     8'h48
`define LTS_A_REP       8'h4C
`define LTS_A_MARK      8'h50
// field positions
`define LTS_CTRL_ONCE   0
`define LTS_CTRL_3PH    1
`define LTS_CMD_TRIG    0
`define LTS_CMD_ABORT   1
`define LTS_CMD_CLEAR   2
// output modes
`define LTS_MODE_AC     2'h0
`define LTS_MODE_DC     2'h1
`define LTS_MODE_COMB   2'h2
// reset values
`define LTS_RST_MODE    2'h0
`define LTS_RST_COUNT   28'h0000001
// limits
`define LTS_LIST_DEPTH  32
`define LTS_REP_MAX     7'h63
`define LTS_COUNT_MAX   28'hBEBC200
`define LTS_DWELL_MAX   27'h55D4A80
`define LTS_PH_MAX      10'h168
`define LTS_SLEW_MAX    32'hFFFFFFFF
`define LTS_SLEW_DMIN   31'h0000001
`define LTS_SLEW_UMAX   31'h3B9ACA00
// timing: one dwell unit is one millisecond
`define LTS_CLK_HZ      20000000
`define LTS_DWELL_UNIT_MS 1
`endif

// ===== src/lts_list.v
`timescale 1ns/1ns
`include "lts_consts.vh"
module lts_list #(
   parameter W = 16
) (
   // clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // load side
   input  wire         clr,
   input  wire         push,
   input  wire [W-1:0] din,
   // read side
   input  wire [4:0]   addr,
   output wire [W-1:0] dout,
   output wire [5:0]   count
);
   reg [W-1:0] mem [0:`LTS_LIST_DEPTH-1];
   reg [5:0]   cnt_q;

   assign count = cnt_q;
   // entries beyond the loaded length read as zero
   assign dout  = ({1'b0, addr} < cnt_q) ? mem[addr] : {W{1'b0}};

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 6'h00;
      end else if (clr) begin
         cnt_q <= 6'h00;
      end else if (push && cnt_q != 6'h20) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   always @(posedge hclk) begin
      if (push && !clr && cnt_q != 6'h20) begin
         mem[cnt_q[4:0]] <= din;
      end
   end
endmodule // lts_list

// ===== tb/lts_chk.sv
`timescale 1ns/1ns
`include "lts_consts.vh"
module lts_chk #(
   parameter ENHANCED = 1
) (
   // bus side
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   // trigger and output stage
   input wire        trig_in,
   input wire [15:0] level_out,
   input wire [1:0]  mode_out,
   input wire [10:0] phase_a_out,
   input wire        marker_out,
   input wire        busy_out
);
   reg       wr_dp_q;
   reg       rd_dp_q;
   reg [7:0] dp_a_q;
   reg       go_q;
   wire      take = hsel & hready & htrans[1];
   wire      list_a = dp_a_q >= `LTS_A_VOLT && dp_a_q <= `LTS_A_MARK;
   // start requests one edge back, so busy rising can be traced to them
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp_q <= 1'b0;
         rd_dp_q <= 1'b0;
         dp_a_q  <= 8'h00;
         go_q    <= 1'b0;
      end else begin
         wr_dp_q <= take & hwrite;
         rd_dp_q <= take & !hwrite;
         if (take) begin
            dp_a_q <= haddr[7:0];
         end
         go_q <= trig_in | (wr_dp_q & (dp_a_q == `LTS_A_CMD) & hwdata[0]);
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus not zero-wait okay");
   property p_start; $rose(busy_out) |-> go_q; endproperty
   a_start: assert property (p_start) else $error("start without trig");
   property p_mark; marker_out |-> busy_out ##1 !marker_out; endproperty
   a_mark: assert property (p_mark) else $error("marker pulse wrong");
   property p_abort; wr_dp_q && list_a && busy_out |-> ##[1:2] !busy_out;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort on write");
   property p_mode; mode_out != 2'h3 && (ENHANCED != 0 || mode_out != 2'h2);
   endproperty
   a_mode: assert property (p_mode) else $error("illegal mode");
   property p_zero; $changed(mode_out) |-> $past(level_out) == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("hot mode switch");
   property p_phase;
      $signed(phase_a_out) >= -360 && $signed(phase_a_out) <= 360;
   endproperty
   a_phase: assert property (p_phase) else $error("phase out of range");
   property p_count; rd_dp_q && list_a |-> hrdata <= 32'h00000020; endproperty
   a_count: assert property (p_count) else $error("bad list count");
   c_run: cover property ($rose(busy_out));
   c_mark: cover property (marker_out);
   c_mode: cover property ($changed(mode_out));
endmodule // lts_chk
bind lts_sequencer lts_chk #(.ENHANCED(ENHANCED)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .trig_in(trig_in), .level_out(level_out), .mode_out(mode_out),
   .phase_a_out(phase_a_out), .marker_out(marker_out), .busy_out(busy_out)
);

// ===== tb/lts_host.sv
`timescale 1ns/1ns
module lts_host (
   // clock
   input  wire         hclk,
   // ahb-lite master
   output logic        hsel,
   output logic [31:0] haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata,
   input  wire         hready,
   input  wire  [31:0] hrdata,
   // trigger
   output logic        trig_in
);
   initial begin
      hsel    = 1'b0;
      haddr   = 32'h00000000;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h00000000;
      trig_in = 1'b0;
   end
   // one single word transfer; read data taken at the closing edge
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // a held level would count once per cycle, so send one-cycle pulses
   task automatic trig;
      trig_in <= 1'b1;
      @(posedge hclk);
      trig_in <= 1'b0;
   endtask
endmodule // lts_host

// ===== tb/lts_sequencer_tb.sv
`timescale 1ns/1ns
`include "lts_consts.vh"
module lts_sequencer_tb;
   logic        hclk = 1'b0;
   logic        hresetn;
   logic        hsel, hwrite, hready, hreadyout, hresp, trig_in;
   logic        marker_out, busy_out;
   logic [31:0] haddr, hwdata, hrdata, slew_out;
   logic [1:0]  htrans, mode_out;
   logic [2:0]  hsize;
   logic [15:0] level_out;
   logic [10:0] pa, pb, pc;
   logic [15:0] seen[$];
   logic [31:0] s0;
   int          n_mismatch = 0;
   int          checks = 0;
   int          marks;
   assign hready = hreadyout;
   always #25 hclk = ~hclk;
   lts_host H (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .trig_in(trig_in));
   lts_sequencer #(.ENHANCED(1), .TICK_CYC(10)) DUT (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .trig_in(trig_in), .level_out(level_out), .slew_out(slew_out),
      .mode_out(mode_out), .phase_a_out(pa), .phase_b_out(pb),
      .phase_c_out(pc), .marker_out(marker_out), .busy_out(busy_out));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      H.xfer(a, 1'b1, d, q);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] q;
      H.xfer(a, 1'b0, 32'h00000000, q);
      chk(q & m, e);
   endtask
   // record the level each busy cycle until the run ends
   task automatic capture;
      int k;
      seen = {};
      marks = 0;
      k = 0;
      while (busy_out !== 1'b1 && k < 50) begin
         @(negedge hclk);
         k++;
      end
      s0 = slew_out;
      while (busy_out === 1'b1 && k < 2000) begin
         seen.push_back(level_out);
         marks += (marker_out === 1'b1);
         @(negedge hclk);
         k++;
      end
      @(posedge hclk);
   endtask
   task automatic t_reset;
      rdm(`LTS_A_MODE, 32'h0);
      rdm(`LTS_A_COUNT, 32'h1);
      rdm(`LTS_A_STATUS, 32'h0);
      rdm(8'h60, 32'h0);
      chk(slew_out, 32'hFFFFFFFF);
   endtask
   task automatic t_auto;
      logic [15:0] e[$];
      wr(`LTS_A_CMD, 32'h4);
      wr(`LTS_A_SLEW, 32'h8000000A);
      for (int i = 0; i < 3; i++) begin
         wr(`LTS_A_VOLT, 11 * (i + 1));
         wr(`LTS_A_DWELL, 32'h1);
         wr(`LTS_A_REP, (i == 1) ? 32'h1 : 32'h0);
         wr(`LTS_A_MARK, (i == 1) ? 32'h0 : 32'h1);
      end
      wr(`LTS_A_REP, 32'h63);
      wr(`LTS_A_REP, 32'h64);
      wr(`LTS_A_SLEW, 32'h0);
      rdm(`LTS_A_VOLT, 32'h3);
      rdm(`LTS_A_REP, 32'h4);
      rdm(`LTS_A_SLEW, 32'h1);
      wr(`LTS_A_COUNT, 32'h2);
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 3; i++)
            repeat ((i == 1) ? 20 : 10) e.push_back(11 * (i + 1));
      H.trig;
      capture;
      chk(seen.size(), e.size());
      for (int i = 0; i < seen.size() && i < e.size(); i++)
         chk(seen[i], e[i]);
      chk(marks, 4);
      chk(s0, 32'h8000000A);
      chk(slew_out, 32'hFFFFFFFF);
      chk(level_out, 16'd33);
      rdm(`LTS_A_STATUS, 32'h0, 32'h3);
   endtask
   task automatic t_once;
      wr(`LTS_A_CTRL, 32'h1);
      wr(`LTS_A_COUNT, 32'h1);
      H.trig;
      repeat (3) @(posedge hclk);
      H.trig;
      repeat (20) @(posedge hclk);
      chk(level_out, 16'd11);
      chk(busy_out, 1'b1);
      H.trig;
      repeat (2) @(posedge hclk);
      chk(level_out, 16'd22);
      wr(`LTS_A_CMD, 32'h2);
      wr(`LTS_A_CTRL, 32'h0);
   endtask
   task automatic t_abort;
      H.trig;
      repeat (5) @(posedge hclk);
      wr(`LTS_A_MARK, 32'h0);
      repeat (2) @(posedge hclk);
      chk(busy_out, 1'b0);
      chk(level_out, 16'd11);
      wr(`LTS_A_LEVEL, 32'h0);
      wr(`LTS_A_CMD, 32'h1);
      repeat (2) @(posedge hclk);
      chk(busy_out, 1'b1);
      chk(level_out, 16'd11);
      wr(`LTS_A_CMD, 32'h2);
      repeat (2) @(posedge hclk);
      chk(busy_out, 1'b0);
   endtask
   task automatic t_mode;
      logic [1:0] mw[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
      logic [1:0] me[4] = '{2'h1, 2'h1, 2'h2, 2'h0};
      for (int i = 0; i < 4; i++) begin
         wr(`LTS_A_LEVEL, 32'h55);
         wr(`LTS_A_MODE, mw[i]);
         repeat (2) @(posedge hclk);
         chk(mode_out, me[i]);
         chk(level_out, (mw[i] == 2'h3) ? 16'h55 : 16'h0);
      end
   endtask
   task automatic t_phase;
      wr(`LTS_A_PHA, 32'hFFFFFFD3);
      wr(`LTS_A_PHB, 32'h78);
      wr(`LTS_A_PHC, 32'hFFFFFF10);
      wr(`LTS_A_PHA, 32'h190);
      wr(`LTS_A_CTRL, 32'h2);
      repeat (2) @(posedge hclk);
      chk(pa, 11'h7D3);
      chk(pb, 11'h04B);
      chk(pc, 11'h6E3);
      wr(`LTS_A_CTRL, 32'h0);
      wr(`LTS_A_PHA, 32'h168);
      repeat (2) @(posedge hclk);
      chk(pb, 11'h000);
      chk(pa, 11'h168);
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      finish_test;
   end
   initial begin
      hresetn = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_auto;
      t_once;
      t_abort;
      t_mode;
      t_phase;
      finish_test;
   end
endmodule // lts_sequencer_tb
